// File: include/ext_irq_cfg.svh
// Constants for the external interrupt input filter block.
//
// Function
// - Five inputs, each with its own noise filter.
// - Pin zero powers up as port input.
// - Pin-function bit zero blocks latch zero setting.
// - Zero/five falling; one-three edge chosen per bit.
// - Zero/five reject under 2, accept 7 periods.
// - One rejects under 15/63, accepts 49/193.
// - Noise select 0 gives 63, 1 gives 15.
// - Two/three reject under 7, accept 25 periods.
// - Low-speed modes reject 1, accept 3.5 periods.
// - Clean edge sets latch within bounded delay.
// - Noise select change effective within 64 periods.
// - Enable needs master, flag, function and routing bits.
// - Output activity on shared pins may raise requests.
// - Control register bit layout, zero reset.
// - Master enable zero blocks every maskable request.
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

`define EIC_NUM_CH         5
`define EIC_CH_ZERO        0
`define EIC_CH_ONE         1
`define EIC_CH_TWO         2
`define EIC_CH_THREE       3
`define EIC_CH_FIVE        4

`define EIC_ADDR           6'h37
`define EIC_BIT_NC         7
`define EIC_BIT_FN         6
`define EIC_BIT_ES3        3
`define EIC_BIT_ES2        2
`define EIC_BIT_ES1        1
`define EIC_RESET          8'h00

// Filter acceptance counts in filter clock periods, between reject and accept limits.
`define EIC_CNT_W          8
`define EIC_CNT_FAST       8'h04
`define EIC_CNT_MID        8'h10
`define EIC_CNT_ONE_SHORT  8'h20
`define EIC_CNT_ONE_LONG   8'h80
`define EIC_CNT_SLOW       8'h02

`endif

// File: include/ext_irq_pkg.sv
// Types for the external interrupt input filter block.
package ext_irq_pkg;

    typedef struct packed {
        logic       master;
        logic [4:0] flags;
        logic       route14;
        logic       route15;
    } irq_enable_t;

    typedef struct packed {
        logic noise_sel;
        logic pin_fn;
        logic es3;
        logic es2;
        logic es1;
    } ctrl_fields_t;

    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

// File: logic/external_interrupt_input_filter.sv
// Noise filters, edge selection and interrupt latches for five external interrupt pins.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"

module external_interrupt_input_filter (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_low_speed_mode,
    input  wire logic [4:0]               i_pins,
    input  wire ext_irq_pkg::sfr_req_t    i_sfr,
    input  wire ext_irq_pkg::irq_enable_t i_enable,
    input  wire logic [4:0]               i_latch_clear,
    output var  logic [7:0]               o_sfr_rdata,
    output var  logic                     o_shared_port_is_irq,
    output var  logic [4:0]               o_irq_latch,
    output var  logic [4:0]               o_irq_request
);
    import ext_irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Acceptance count per channel for the current clock mode and noise select.
    function automatic logic [`EIC_CNT_W-1:0] accept_count(input int ch, input logic nc, input logic slow);
        logic [`EIC_CNT_W-1:0] n;
        n = `EIC_CNT_FAST;
        if (slow) begin
            n = `EIC_CNT_SLOW;
        end else if (ch == `EIC_CH_ONE) begin
            n = nc ? `EIC_CNT_ONE_SHORT : `EIC_CNT_ONE_LONG;
        end else if (ch == `EIC_CH_TWO || ch == `EIC_CH_THREE) begin
            n = `EIC_CNT_MID;
        end else begin
            n = `EIC_CNT_FAST;
        end
        return n;
    endfunction

    // Selected edge seen when the filtered level flips to new_level.
    function automatic logic edge_hit(input logic new_level, input logic falling_sel);
        return falling_sel ? ~new_level : new_level;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Control register.
    logic [7:0]   ctrl_r;
    logic [7:0]   ctrl_nxt;
    ctrl_fields_t fields;
    wire  logic   ctrl_hit;

    assign ctrl_hit = (i_sfr.addr == `EIC_ADDR);
    assign ctrl_nxt = (ctrl_hit && i_sfr.wr) ? i_sfr.wdata : ctrl_r;
    assign fields   = '{noise_sel: ctrl_r[`EIC_BIT_NC], pin_fn: ctrl_r[`EIC_BIT_FN],
                        es3: ctrl_r[`EIC_BIT_ES3], es2: ctrl_r[`EIC_BIT_ES2],
                        es1: ctrl_r[`EIC_BIT_ES1]};

    // Read view of the register; bits 5, 4 and 0 are stored in ctrl_r but read as zero.
    wire logic [7:0] ctrl_view;
    assign ctrl_view[`EIC_BIT_NC]  = fields.noise_sel;
    assign ctrl_view[`EIC_BIT_FN]  = fields.pin_fn;
    assign ctrl_view[5]            = 1'b0;
    assign ctrl_view[4]            = 1'b0;
    assign ctrl_view[`EIC_BIT_ES3] = fields.es3;
    assign ctrl_view[`EIC_BIT_ES2] = fields.es2;
    assign ctrl_view[`EIC_BIT_ES1] = fields.es1;
    assign ctrl_view[0]            = 1'b0;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r      <= `EIC_RESET;
            o_sfr_rdata <= 8'h00;
        end else begin
            ctrl_r      <= ctrl_nxt;
            o_sfr_rdata <= (ctrl_hit && i_sfr.rd) ? ctrl_view : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Synchroniser, filter and edge detection per pin.
    logic [4:0]            sync1_r;
    logic [4:0]            sync2_r;
    logic [4:0]            filt_r;
    logic [4:0]            filt_nxt;
    logic [`EIC_CNT_W-1:0] cnt_r   [`EIC_NUM_CH];
    logic [`EIC_CNT_W-1:0] cnt_nxt [`EIC_NUM_CH];
    logic [4:0]            falling_sel;
    logic [4:0]            edge_ev;
    logic [4:0]            set_ok;
    logic [4:0]            enabled;
    logic [4:0]            latch_nxt;

    // Channels zero and five are fixed to falling edges; the others follow their select bit.
    assign falling_sel[`EIC_CH_ZERO]  = 1'b1;
    assign falling_sel[`EIC_CH_ONE]   = fields.es1;
    assign falling_sel[`EIC_CH_TWO]   = fields.es2;
    assign falling_sel[`EIC_CH_THREE] = fields.es3;
    assign falling_sel[`EIC_CH_FIVE]  = 1'b1;

    // Acceptance limit per channel for the current clock mode and noise select.
    // A noise select change reaches the limit in the same cycle that the write lands in ctrl_r.
    logic [`EIC_CNT_W-1:0] limit [`EIC_NUM_CH];
    assign limit[`EIC_CH_ZERO]  = accept_count(`EIC_CH_ZERO, fields.noise_sel, i_low_speed_mode);
    assign limit[`EIC_CH_ONE]   = accept_count(`EIC_CH_ONE, fields.noise_sel, i_low_speed_mode);
    assign limit[`EIC_CH_TWO]   = accept_count(`EIC_CH_TWO, fields.noise_sel, i_low_speed_mode);
    assign limit[`EIC_CH_THREE] = accept_count(`EIC_CH_THREE, fields.noise_sel, i_low_speed_mode);
    assign limit[`EIC_CH_FIVE]  = accept_count(`EIC_CH_FIVE, fields.noise_sel, i_low_speed_mode);

    // Only the pin function bit gates the latch of channel zero.
    assign set_ok = {4'b1111, fields.pin_fn};

    // Per-channel enable terms; the master enable gates every channel alike.
    // The latches themselves are not gated, so a pending edge survives a disabled period.
    wire logic gate_zero;
    wire logic gate_one;
    wire logic gate_two;
    wire logic gate_three;
    wire logic gate_five;

    assign gate_zero  = i_enable.master & i_enable.flags[`EIC_CH_ZERO] & fields.pin_fn;
    assign gate_one   = i_enable.master & i_enable.flags[`EIC_CH_ONE];
    assign gate_two   = i_enable.master & i_enable.flags[`EIC_CH_TWO];
    assign gate_three = i_enable.master & i_enable.flags[`EIC_CH_THREE] & ~i_enable.route14;
    assign gate_five  = i_enable.master & i_enable.flags[`EIC_CH_FIVE] & ~i_enable.route15;
    assign enabled    = {gate_five, gate_three, gate_two, gate_one, gate_zero};

    // Each channel counts consecutive synchronised samples that differ from the filtered level.
    // Any sample that agrees again drops the count to zero, so a short pulse leaves no trace.
    always_comb begin
        for (int ch = 0; ch < `EIC_NUM_CH; ch++) begin
            filt_nxt[ch] = filt_r[ch];
            edge_ev[ch]  = 1'b0;
            cnt_nxt[ch]  = '0;
            if (sync2_r[ch] != filt_r[ch]) begin
                cnt_nxt[ch] = cnt_r[ch] + `EIC_CNT_W'(1);
                if (cnt_nxt[ch] >= limit[ch]) begin
                    filt_nxt[ch] = sync2_r[ch];
                    cnt_nxt[ch]  = '0;
                    edge_ev[ch]  = edge_hit(sync2_r[ch], falling_sel[ch]);
                end
            end
        end
    end

    // A set in the same cycle as a clear wins, so no edge is lost.
    assign latch_nxt = (o_irq_latch & ~i_latch_clear) | (edge_ev & set_ok);

    // The first stage is read only by the second, so a metastable sample stays inside the pair.
    // Both stages reset to the idle high level, so no false edge follows reset.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_r <= 5'h1f;
            sync2_r <= 5'h1f;
        end else begin
            sync1_r <= i_pins;
            sync2_r <= sync1_r;
        end
    end

    // Filtered level per channel, also idle high after reset.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            filt_r <= 5'h1f;
        end else begin
            filt_r <= filt_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int ch = 0; ch < `EIC_NUM_CH; ch++) begin
                cnt_r[ch] <= '0;
            end
        end else begin
            for (int ch = 0; ch < `EIC_NUM_CH; ch++) begin
                cnt_r[ch] <= cnt_nxt[ch];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latches and gated requests.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_latch          <= 5'h00;
            o_irq_request        <= 5'h00;
            o_shared_port_is_irq <= 1'b0;
        end else begin
            o_irq_latch          <= latch_nxt;
            o_irq_request        <= latch_nxt & enabled;
            o_shared_port_is_irq <= fields.pin_fn;
        end
    end

endmodule
`default_nettype wire

// File: test/pin_src.sv
// Behavioural source that drives the five external interrupt pins.
`timescale 1ns/1ps
`default_nettype none
module pin_src (
    input  wire logic       i_clk,
    output var  logic [4:0] o_pins
);
    initial o_pins = 5'h1f;
    // Pins idle high and only ever act as inputs to the block.
    task drive(input int ch, input int n);
        if (n > 0) begin
            @(posedge i_clk);
            #1 o_pins[ch] = 1'b0;
            repeat (n) @(posedge i_clk);
            #1 o_pins[ch] = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// File: test/external_interrupt_input_filter_props.sv
// Port checks for the external interrupt filter.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"
module external_interrupt_input_filter_props (
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire logic [4:0]               i_pins,
    input wire ext_irq_pkg::sfr_req_t    i_sfr,
    input wire ext_irq_pkg::irq_enable_t i_enable,
    input wire logic [4:0]               i_latch_clear,
    input wire logic [7:0]               o_sfr_rdata,
    input wire logic                     o_shared_port_is_irq,
    input wire logic [4:0]               o_irq_latch,
    input wire logic [4:0]               o_irq_request
);
    import ext_irq_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_wr;
        i_sfr.wr && i_sfr.addr == `EIC_ADDR;
    endsequence
    a_master_block: assert property (
        !i_enable.master && $past(!i_enable.master) |-> o_irq_request == 5'h00) else $error("no master");
    a_flag_block: assert property (
        (o_irq_request & ~i_enable.flags & ~$past(i_enable.flags)) == 5'h00) else $error("no flag");
    a_route_block: assert property (
        i_enable.route14 && $past(i_enable.route14) |-> !o_irq_request[3]) else $error("routed");
    a_zero_block: assert property (
        !o_shared_port_is_irq |-> !$rose(o_irq_latch[0])) else $error("port mode set");
    a_latch_hold: assert property (
        ($past(o_irq_latch) & ~$past(i_latch_clear) & ~o_irq_latch) == 5'h00) else $error("latch lost");
    a_sync_delay: assert property (
        $rose(o_irq_latch[0]) |-> !$past(i_pins[0], 2) && !$past(i_pins[0], 3)) else $error("too fast");
    a_rd_field: assert property (
        i_sfr.rd && i_sfr.addr == `EIC_ADDR |=> (o_sfr_rdata & 8'h31) == 8'h00) else $error("bits");
    a_rd_idle: assert property (
        !(i_sfr.rd && i_sfr.addr == `EIC_ADDR) |=> o_sfr_rdata == 8'h00) else $error("rdata");
    a_fn_follow: assert property (
        s_wr ##1 !i_sfr.wr |=> o_shared_port_is_irq == $past(i_sfr.wdata[6], 2)) else $error("fn");
endmodule
`default_nettype wire

// File: test/external_interrupt_input_filter_test.sv
// Self-checking bench for the external interrupt filter.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"
module external_interrupt_input_filter_test;
    import ext_irq_pkg::*;
    logic        i_clk, i_rst, slow, fn;
    logic [4:0]  pins, clr, lat, req, last = '0;
    logic [7:0]  rdata, ctl;
    sfr_req_t    sfr;
    irq_enable_t en;
    logic [4:0]  q[$];
    int          fail_count = 0, check_count = 0, cyc = 0;
    external_interrupt_input_filter u_dut (.i_clk, .i_rst, .i_low_speed_mode(slow), .i_pins(pins),
        .i_sfr(sfr), .i_enable(en), .i_latch_clear(clr), .o_sfr_rdata(rdata),
        .o_shared_port_is_irq(fn), .o_irq_latch(lat), .o_irq_request(req));
    pin_src u_src (.i_clk, .o_pins(pins));
    task chk(input string nm, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task bus(input logic [5:0] a, input logic w, input logic [7:0] d);
        @(posedge i_clk);
        #1 sfr = '{a, w, !w, d};
        @(posedge i_clk);
        #1 sfr = '0;
    endtask
    task hit(input int ch, input int rj, input int ac);
        int k;
        u_src.drive(ch, rj);
        q.push_back(5'h01 << ch);
        u_src.drive(ch, ac);
        chk("edge", lat[ch], (ch == 0 || ch == 4) ? 1'b1 : ctl[ch]);
        for (k = 0; k < 300 && lat[ch] !== 1'b1; k++) @(posedge i_clk);
        #1 chk("req", req, lat & {5{en.master}} & en.flags & {~en.route15, ~en.route14, 3'h7});
        chk("set", {7'h00, lat[ch]}, 8'h01);
        q.push_back(5'h00);
        clr = 5'h01 << ch;
        @(posedge i_clk);
        #1 clr = '0;
        repeat (8) @(posedge i_clk);
    endtask
    initial begin
        i_clk = 0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (!i_rst && lat !== last) begin
            chk("latch", lat, q.size() ? q.pop_front() : ~lat);
            last = lat;
        end
        if (cyc == 30000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        i_rst = 1'b1;
        slow = 1'b0;
        clr = '0;
        sfr = '0;
        en = '0;
        void'($urandom(94));
        repeat (4) @(posedge i_clk);
        #1 i_rst = 0;
        bus(`EIC_ADDR, 0, 0);
        chk("ctrl", rdata, `EIC_RESET);
        chk("port", fn, 0);
        bus(6'h36, 0, 0);
        chk("unmapped", rdata, 0);
        u_src.drive(0, 9);
        for (int r = 0; r < 4; r++) begin
            en = '0;
            ctl = {r[0], 7'h40} | ($urandom & 8'h0e);
            bus(`EIC_ADDR, 1, ctl | 8'h31);
            bus(`EIC_ADDR, 0, 0);
            chk("ctrl", rdata, ctl);
            repeat (64) @(posedge i_clk);
            en = 9'($urandom);
            slow = (r == 3);
            for (int c = 0; c < 5; c++)
                if (slow) hit(c, 0, 5);
                else if (c == 1) hit(c, ctl[7] ? 14 : 62, ctl[7] ? 49 : 193);
                else if (c == 2 || c == 3) hit(c, 6, 25);
                else hit(c, 1, 7);
        end
        repeat (4) @(posedge i_clk);
        chk("queue", 8'(q.size()), 8'h00);
        end_of_test;
    end
endmodule
bind external_interrupt_input_filter external_interrupt_input_filter_props u_props (.i_clk, .i_rst,
    .i_pins, .i_sfr, .i_enable, .i_latch_clear, .o_sfr_rdata, .o_shared_port_is_irq, .o_irq_latch,
    .o_irq_request);
`default_nettype wire
